// [hdl/ext_bank_pkg.sv]
package ext_bank_pkg;
  localparam int num_regions = 4;
  // Register offsets on the plain register port (byte addresses).
  localparam logic [7:0] off_region_base_0 = 8'h00;
  localparam logic [7:0] off_wait_states = 8'h10;
  localparam logic [7:0] off_sys_cfg = 8'h14;
  localparam logic [7:0] off_status = 8'h18;
  localparam logic [7:0] off_mask = 8'h1c;
  localparam logic [7:0] off_state = 8'h20;
  // Field positions inside a region configuration word (bit 0 is the LSB, bit 31 the MSB).
  localparam int f_match_hi = 31;
  localparam int f_match_lo = 15;
  localparam int f_type_hi = 14;
  localparam int f_type_lo = 12;
  localparam int f_port_hi = 11;
  localparam int f_port_lo = 10;
  localparam int f_short_setup = 9;
  localparam int f_write_protect = 8;
  localparam int f_burst_length = 6;
  localparam int f_strobe_func = 5;
  localparam int f_toggle_beat = 4;
  localparam int f_late_beat = 3;
  localparam int f_ext_ack = 2;
  localparam int f_valid = 0;
  // Writable bits of a region word; bits 7 and 1 are reserved and read as zero.
  localparam logic [31:0] region_wmask = 32'hffff_ff7d;
  localparam logic [31:0] region_reset = 32'h0000_0000;
  // Mask register per region: address_mask in 31:15, type_mask in 14:12.
  localparam logic [31:0] amask_reset = 32'h0000_0000;
  localparam logic [1:0] port_32 = 2'h0;
  localparam logic [1:0] port_8 = 2'h1;
  localparam logic [1:0] port_16 = 2'h2;
  localparam int st_write_violation = 0;
  localparam int st_cycle_done = 1;
  localparam int st_reset_taken = 2;
  localparam logic [3:0] wait_reset = 4'h2;
  localparam logic [3:0] beats_short = 4'h4;
  localparam logic [3:0] beats_long = 4'h8;

  typedef struct packed {
    logic valid;
    logic write;
    logic burst;
    logic [31:0] addr;
    logic [2:0] addr_type;
    logic [1:0] size;
    logic [31:0] wdata;
  } bus_req_t;

  typedef enum logic [4:0] {
    s_idle = 5'b00001,
    s_start = 5'b00010,
    s_wait = 5'b00100,
    s_beat = 5'b01000,
    s_done = 5'b10000
  } cyc_state_t;
endpackage

// [hdl/external_bank_memory_controller.sv]
`timescale 1ns/100ps
`default_nettype none
// Contract
// [R1] Compare match_value with unmasked address bits.
// [R2] Compare three-bit address_type under type_mask.
// [R3] port_size: 00=32, 01=8, 10=16, 11 reserved.
// [R4] short_setup selects shortened setup per region.
// [R5] Software avoids short setup with divided bus.
// [R6] Write-protected: no chip_select, no transfer_ack.
// [R7] Protected write sets write_violation_flag.
// [R8] burst_length: 4 or 8 beats, when allowed.
// [R9] strobe_function_sel: write strobes or byte selects.
// [R10] toggle_beat_strobe sets beat strobe duration.
// [R11] late_beat_strobe delays first strobe by waits.
// [R12] Software never sets both beat-strobe bits.
// [R13] external_ack_sel: internal or outside transfer_ack.
// [R14] Split wide operands into coherent narrow cycles.
// [R15] Reset waits until cycle finishes or never starts.
// [R16] Misaligned core splits carry no coherency.
// [R17] chip_select needs address, type match, permission.
module external_bank_memory_controller (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire ext_bank_pkg::bus_req_t req,
  output logic req_ready,
  output logic req_done,
  output logic req_error,
  output logic [31:0] req_rdata,
  input wire logic soft_reset_req,
  input wire logic hard_reset_req,
  output logic soft_reset,
  output logic hard_reset,
  output logic [31:0] ext_addr,
  output logic [31:0] ext_wdata,
  input wire logic [31:0] ext_rdata,
  output logic ext_data_oe_n,
  output logic ext_rd_wr,
  output logic transfer_begin_strobe,
  output logic [3:0] chip_select,
  output logic [3:0] write_strobe,
  output logic [3:0] byte_lane_select,
  output logic output_strobe,
  output logic burst_beat_strobe,
  output logic transfer_ack,
  input wire logic ext_transfer_ack,
  output logic transfer_error_ack,
  output logic irq
);
  logic [31:0] region_q [ext_bank_pkg::num_regions];
  logic [31:0] amask_q [ext_bank_pkg::num_regions];
  logic [3:0] wait_states_q;
  logic burst_allow_q;
  logic bus_monitor_en_q;
  logic [2:0] status_q;
  logic [2:0] mask_q;
  ext_bank_pkg::cyc_state_t state_q;
  ext_bank_pkg::bus_req_t cur_q;
  logic [1:0] sel_q;
  logic [31:0] cfg_q;
  logic [3:0] wcnt_q;
  logic [3:0] beat_q;
  logic [3:0] beats_q;
  logic [1:0] piece_q;
  logic [1:0] pieces_q;
  logic [31:0] rbuf_q;
  logic pend_soft_q;
  logic pend_hard_q;
  logic [3:0] hit;
  logic [1:0] hit_idx;
  logic any_hit;
  logic [31:0] hit_cfg;
  logic take;
  logic violation;
  logic ack_in;
  logic last_piece;
  logic last_beat;
  logic [1:0] npieces;
  logic [3:0] nbeats;
  logic [31:0] piece_addr;
  logic [31:0] piece_data;
  logic [3:0] piece_lanes;

  // The mask selects which address bits must match; the same mask word carries the type mask.
  always_comb begin
    hit = 4'h0;
    for (int i = 0; i < ext_bank_pkg::num_regions; i++) begin
      hit[i] = region_q[i][ext_bank_pkg::f_valid] &&
        (((req.addr[31:15] ^ region_q[i][ext_bank_pkg::f_match_hi:ext_bank_pkg::f_match_lo]) &
          amask_q[i][ext_bank_pkg::f_match_hi:ext_bank_pkg::f_match_lo]) == 17'h0) && // [R1]
        (((req.addr_type ^ region_q[i][ext_bank_pkg::f_type_hi:ext_bank_pkg::f_type_lo]) &
          amask_q[i][ext_bank_pkg::f_type_hi:ext_bank_pkg::f_type_lo]) == 3'h0); // [R2]
    end
  end

  // Lowest-numbered region wins when regions overlap.
  always_comb begin
    hit_idx = 2'h0;
    for (int i = ext_bank_pkg::num_regions - 1; i >= 0; i--) begin
      if (hit[i]) begin
        hit_idx = 2'(i);
      end
    end
  end

  assign any_hit = |hit;
  assign hit_cfg = region_q[hit_idx];
  // A pending reset blocks new cycles so an access either completes or never starts.
  assign take = req.valid && req_ready && !pend_soft_q && !pend_hard_q && !soft_reset_req &&
    !hard_reset_req; // [R15]
  assign violation = take && req.write && any_hit && hit_cfg[ext_bank_pkg::f_write_protect]; // [R6]
  assign ack_in = cur_q.valid ? (cfg_q[ext_bank_pkg::f_ext_ack] ? ext_transfer_ack : (wcnt_q == 4'h0))
    : 1'b0; // [R13]
  assign last_piece = (piece_q == pieces_q);
  assign last_beat = (beat_q == beats_q);

  // Number of port cycles per operand, less one: size 0=byte, 1=half, 2=word.
  always_comb begin
    npieces = 2'h0;
    unique case (hit_cfg[ext_bank_pkg::f_port_hi:ext_bank_pkg::f_port_lo])
      ext_bank_pkg::port_8: npieces = (req.size == 2'h2) ? 2'h3 : ((req.size == 2'h1) ? 2'h1 : 2'h0);
      ext_bank_pkg::port_16: npieces = (req.size == 2'h2) ? 2'h1 : 2'h0;
      default: npieces = 2'h0;
    endcase // [R3] [R14]
    nbeats = 4'h0;
    if (req.burst && burst_allow_q) begin
      nbeats = hit_cfg[ext_bank_pkg::f_burst_length] ? ext_bank_pkg::beats_long - 4'h1
        : ext_bank_pkg::beats_short - 4'h1; // [R8]
    end
  end

  // Narrow pieces go out most-significant first on the upper lanes, big-endian style.
  always_comb begin
    piece_addr = cur_q.addr;
    piece_data = cur_q.wdata;
    piece_lanes = 4'hf;
    unique case (cfg_q[ext_bank_pkg::f_port_hi:ext_bank_pkg::f_port_lo])
      ext_bank_pkg::port_8: begin
        piece_addr = cur_q.addr + {30'h0, piece_q};
        piece_data = cur_q.wdata << {(2'h3 - (pieces_q - piece_q)), 3'h0};
        piece_data = {piece_data[31:24], 24'h0};
        piece_lanes = 4'h8;
      end
      ext_bank_pkg::port_16: begin
        piece_addr = cur_q.addr + {30'h0, piece_q[0], 1'b0};
        piece_data = (pieces_q != 2'h0 && piece_q == 2'h1) ? {cur_q.wdata[15:0], 16'h0}
          : ((pieces_q == 2'h0) ? {cur_q.wdata[15:0], 16'h0} : {cur_q.wdata[31:16], 16'h0});
        piece_lanes = 4'hc;
      end
      default: piece_lanes = 4'hf;
    endcase // [R14]
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      for (int i = 0; i < ext_bank_pkg::num_regions; i++) begin
        region_q[i] <= ext_bank_pkg::region_reset;
        amask_q[i] <= ext_bank_pkg::amask_reset;
      end
      wait_states_q <= ext_bank_pkg::wait_reset;
      burst_allow_q <= 1'b0;
      bus_monitor_en_q <= 1'b0;
      mask_q <= 3'h0;
    end else if (reg_wr) begin
      for (int i = 0; i < ext_bank_pkg::num_regions; i++) begin
        if (reg_addr == ext_bank_pkg::off_region_base_0 + 8'(4 * i)) begin
          region_q[i] <= reg_wdata & ext_bank_pkg::region_wmask;
        end
        if (reg_addr == ext_bank_pkg::off_state + 8'(4 * (i + 1))) begin
          amask_q[i] <= {reg_wdata[31:12], 12'h0};
        end
      end
      if (reg_addr == ext_bank_pkg::off_wait_states) begin
        wait_states_q <= reg_wdata[3:0];
      end
      if (reg_addr == ext_bank_pkg::off_sys_cfg) begin
        burst_allow_q <= reg_wdata[0];
        bus_monitor_en_q <= reg_wdata[1];
      end
      if (reg_addr == ext_bank_pkg::off_mask) begin
        mask_q <= reg_wdata[2:0];
      end
    end
  end

  // Set beats clear so an event in the clearing cycle survives.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      status_q <= 3'h0;
    end else begin
      status_q <= (status_q & ~((reg_wr && reg_addr == ext_bank_pkg::off_status) ? reg_wdata[2:0] : 3'h0)) |
        {(soft_reset && !soft_reset_req) || (hard_reset && !hard_reset_req), req_done && !req_error,
         violation}; // [R7]
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      reg_rdata <= 32'h0;
    end else begin
      reg_rdata <= 32'h0;
      if (reg_rd) begin
        for (int i = 0; i < ext_bank_pkg::num_regions; i++) begin
          if (reg_addr == ext_bank_pkg::off_region_base_0 + 8'(4 * i)) begin
            reg_rdata <= region_q[i];
          end
          if (reg_addr == ext_bank_pkg::off_state + 8'(4 * (i + 1))) begin
            reg_rdata <= amask_q[i];
          end
        end
        unique case (reg_addr)
          ext_bank_pkg::off_wait_states: reg_rdata <= {28'h0, wait_states_q};
          ext_bank_pkg::off_sys_cfg: reg_rdata <= {30'h0, bus_monitor_en_q, burst_allow_q};
          ext_bank_pkg::off_status: reg_rdata <= {29'h0, status_q};
          ext_bank_pkg::off_mask: reg_rdata <= {29'h0, mask_q};
          ext_bank_pkg::off_state: reg_rdata <= {21'h0, pend_hard_q, pend_soft_q, sel_q, piece_q, state_q};
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_q & mask_q);
    end
  end

  // Reset requests are held until the bus is idle, then driven for one cycle.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      pend_soft_q <= 1'b0;
      pend_hard_q <= 1'b0;
      soft_reset <= 1'b0;
      hard_reset <= 1'b0;
    end else begin
      soft_reset <= 1'b0;
      hard_reset <= 1'b0;
      if (state_q == ext_bank_pkg::s_idle && !cur_q.valid && (pend_soft_q || pend_hard_q)) begin
        hard_reset <= pend_hard_q;
        soft_reset <= pend_hard_q | pend_soft_q; // [R15]
        pend_soft_q <= 1'b0;
        pend_hard_q <= 1'b0;
      end else begin
        pend_soft_q <= pend_soft_q | soft_reset_req;
        pend_hard_q <= pend_hard_q | hard_reset_req;
      end
    end
  end

  // Cycle engine: one start cycle, setup and waits, then data beats per port piece.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_q <= ext_bank_pkg::s_idle;
      cur_q <= '0;
      sel_q <= 2'h0;
      cfg_q <= 32'h0;
      wcnt_q <= 4'h0;
      beat_q <= 4'h0;
      beats_q <= 4'h0;
      piece_q <= 2'h0;
      pieces_q <= 2'h0;
      rbuf_q <= 32'h0;
      req_ready <= 1'b0;
      req_done <= 1'b0;
      req_error <= 1'b0;
      req_rdata <= 32'h0;
    end else begin
      req_done <= 1'b0;
      req_error <= 1'b0;
      unique case (state_q)
        ext_bank_pkg::s_idle: begin
          req_ready <= !pend_soft_q && !pend_hard_q;
          if (take) begin
            req_ready <= 1'b0;
            if (!any_hit || violation) begin
              req_done <= 1'b1; // [R6]
              req_error <= bus_monitor_en_q || !any_hit;
            end else begin
              cur_q <= req;
              sel_q <= hit_idx;
              cfg_q <= hit_cfg;
              pieces_q <= npieces;
              beats_q <= nbeats;
              piece_q <= 2'h0;
              beat_q <= 4'h0;
              rbuf_q <= 32'h0;
              state_q <= ext_bank_pkg::s_start;
            end
          end
        end
        ext_bank_pkg::s_start: begin
          wcnt_q <= cfg_q[ext_bank_pkg::f_short_setup] ? wait_states_q - 4'h1 : wait_states_q; // [R4]
          state_q <= ext_bank_pkg::s_wait;
        end
        ext_bank_pkg::s_wait: begin
          if (wcnt_q != 4'h0 && wcnt_q != 4'hf) begin
            wcnt_q <= wcnt_q - 4'h1;
          end
          if (ack_in || wcnt_q == 4'hf) begin
            state_q <= ext_bank_pkg::s_beat;
          end
        end
        ext_bank_pkg::s_beat: begin
          rbuf_q <= (cfg_q[ext_bank_pkg::f_port_hi:ext_bank_pkg::f_port_lo] == ext_bank_pkg::port_32) ?
            ext_rdata : ((cfg_q[ext_bank_pkg::f_port_hi:ext_bank_pkg::f_port_lo] == ext_bank_pkg::port_16) ?
            {rbuf_q[15:0], ext_rdata[31:16]} : {rbuf_q[23:0], ext_rdata[31:24]}); // [R14]
          if (!last_beat) begin
            beat_q <= beat_q + 4'h1;
            wcnt_q <= wait_states_q;
            state_q <= ext_bank_pkg::s_wait;
          end else if (!last_piece) begin
            piece_q <= piece_q + 2'h1;
            beat_q <= 4'h0;
            state_q <= ext_bank_pkg::s_start;
          end else begin
            state_q <= ext_bank_pkg::s_done;
          end
        end
        ext_bank_pkg::s_done: begin
          // Data is handed back only once all pieces are in, so a split operand is seen whole.
          req_done <= 1'b1;
          req_rdata <= rbuf_q; // [R14] [R16]
          cur_q.valid <= 1'b0;
          req_ready <= 1'b0;
          state_q <= ext_bank_pkg::s_idle;
        end
        default: state_q <= ext_bank_pkg::s_idle;
      endcase
    end
  end

  // Pin drive is registered from the engine state for glitch-free strobes.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ext_addr <= 32'h0;
      ext_wdata <= 32'h0;
      ext_data_oe_n <= 1'b1;
      ext_rd_wr <= 1'b1;
      transfer_begin_strobe <= 1'b0;
      chip_select <= 4'h0;
      write_strobe <= 4'h0;
      byte_lane_select <= 4'h0;
      output_strobe <= 1'b0;
      burst_beat_strobe <= 1'b0;
      transfer_ack <= 1'b0;
      transfer_error_ack <= 1'b0;
    end else begin
      transfer_begin_strobe <= (state_q == ext_bank_pkg::s_start);
      transfer_error_ack <= violation && bus_monitor_en_q; // [R6]
      ext_addr <= piece_addr + {26'h0, beat_q, 2'h0};
      ext_wdata <= piece_data;
      ext_rd_wr <= !cur_q.write;
      ext_data_oe_n <= !(cur_q.valid && cur_q.write && state_q != ext_bank_pkg::s_idle);
      chip_select <= 4'h0;
      write_strobe <= 4'h0;
      byte_lane_select <= 4'h0;
      output_strobe <= 1'b0;
      if (state_q != ext_bank_pkg::s_idle && state_q != ext_bank_pkg::s_done) begin
        chip_select[sel_q] <= 1'b1; // [R17]
        if (cfg_q[ext_bank_pkg::f_strobe_func]) begin
          byte_lane_select <= piece_lanes; // [R9]
        end else if (cur_q.write && state_q != ext_bank_pkg::s_start) begin
          write_strobe <= piece_lanes; // [R9]
        end
        output_strobe <= !cur_q.write && state_q != ext_bank_pkg::s_start;
      end
      transfer_ack <= (state_q == ext_bank_pkg::s_beat) && !cfg_q[ext_bank_pkg::f_ext_ack]; // [R13]
      burst_beat_strobe <= 1'b0;
      if (beats_q != 4'h0 && !last_beat) begin
        if (cfg_q[ext_bank_pkg::f_toggle_beat]) begin
          burst_beat_strobe <= (state_q == ext_bank_pkg::s_wait) && ack_in; // [R10]
        end else if (cfg_q[ext_bank_pkg::f_late_beat]) begin
          burst_beat_strobe <= (state_q == ext_bank_pkg::s_wait && (wcnt_q == 4'h0 || beat_q != 4'h0)) ||
            state_q == ext_bank_pkg::s_beat; // [R11]
        end else begin
          burst_beat_strobe <= state_q == ext_bank_pkg::s_wait || state_q == ext_bank_pkg::s_beat; // [R11]
        end
      end
    end
  end
endmodule
`default_nettype wire

// [dv/ext_bank_props.sv]
`timescale 1ns/100ps
`default_nettype none
module ext_bank_props (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic req_done,
  input wire logic req_error,
  input wire logic soft_reset,
  input wire logic hard_reset,
  input wire logic ext_data_oe_n,
  input wire logic ext_rd_wr,
  input wire logic transfer_begin_strobe,
  input wire logic [3:0] chip_select,
  input wire logic transfer_ack,
  input wire logic transfer_error_ack
);
  // Shadow copies of the protect and enable bits, so selects are judged against the live setup.
  logic [3:0] wp_q;
  logic [3:0] en_q;
  always_ff @(posedge clock) begin
    if (!rstn) begin
      wp_q <= 4'h0;
      en_q <= 4'h0;
    end else if (reg_wr && reg_addr[7:4] == 4'h0 && reg_addr[1:0] == 2'h0) begin
      wp_q[reg_addr[3:2]] <= reg_wdata[ext_bank_pkg::f_write_protect];
      en_q[reg_addr[3:2]] <= reg_wdata[ext_bank_pkg::f_valid];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence s_begin;
    transfer_begin_strobe ##1 !transfer_begin_strobe;
  endsequence
  sequence s_quiet;
    chip_select == 4'h0 && !transfer_ack;
  endsequence
  property p_begin_pulse;
    transfer_begin_strobe |-> s_begin;
  endproperty
  a_begin_pulse: assert property (p_begin_pulse) else $error("begin strobe too long");
  property p_one_select;
    $onehot0(chip_select);
  endproperty
  a_one_select: assert property (p_one_select) else $error("two selects at once");
  property p_select_enabled;
    (chip_select & ~en_q) == 4'h0;
  endproperty
  a_select_enabled: assert property (p_select_enabled) else $error("select of a disabled region");
  property p_protect_select;
    !ext_rd_wr |-> (chip_select & wp_q) == 4'h0;
  endproperty
  a_protect_select: assert property (p_protect_select) else $error("select on protected write");
  property p_error_quiet;
    transfer_error_ack |-> s_quiet;
  endproperty
  a_error_quiet: assert property (p_error_quiet) else $error("error ack beside select or ack");
  property p_error_done;
    req_error |-> req_done;
  endproperty
  a_error_done: assert property (p_error_done) else $error("error without done");
  property p_done_pulse;
    req_done |=> !req_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
  property p_reset_idle;
    soft_reset |-> s_quiet and !transfer_begin_strobe;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("reset driven inside a cycle");
  property p_hard_soft;
    hard_reset |-> soft_reset;
  endproperty
  a_hard_soft: assert property (p_hard_soft) else $error("hard reset without soft reset");
  property p_drive_write;
    !ext_data_oe_n |-> !ext_rd_wr;
  endproperty
  a_drive_write: assert property (p_drive_write) else $error("data driven on a read");
endmodule
`default_nettype wire

// [dv/ext_mem_model.sv]
`timescale 1ns/100ps
`default_nettype none
module ext_mem_model (
  input wire logic clock,
  input wire logic [3:0] chip_select,
  input wire logic [31:0] ext_addr,
  input wire logic [3:0] ack_delay,
  output logic [31:0] ext_rdata,
  output logic ext_transfer_ack
);
  logic [31:0] last_q = 32'h0;
  logic [3:0] cnt_q = 4'h0;
  // Unselected lines show the inverse of the last word, so a stale sample never matches.
  assign ext_rdata = (chip_select != 4'h0) ? (ext_addr ^ 32'h5a5a_0000) : ~last_q;
  always_ff @(posedge clock) begin
    if (chip_select != 4'h0) begin
      last_q <= ext_addr ^ 32'h5a5a_0000;
    end
  end
  always_ff @(posedge clock) begin
    if (chip_select == 4'h0) begin
      cnt_q <= 4'h0;
      ext_transfer_ack <= 1'b0;
    end else if (cnt_q == ack_delay) begin
      cnt_q <= 4'h0;
      ext_transfer_ack <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 4'h1;
      ext_transfer_ack <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [dv/external_bank_memory_controller_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module external_bank_memory_controller_bench;
  logic clock, rstn, reg_wr, reg_rd, soft_reset_req, hard_reset_req, req_ready, req_done, req_error;
  logic soft_reset, hard_reset, ext_data_oe_n, ext_rd_wr, transfer_begin_strobe, output_strobe, irq;
  logic burst_beat_strobe, transfer_ack, ext_transfer_ack, transfer_error_ack, tea_or, bbs_or, got_err;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, req_rdata, ext_addr, ext_wdata, ext_rdata, got_rd, v;
  logic [3:0] chip_select, write_strobe, byte_lane_select, ack_delay, cs_or, ws_or, bls_or;
  ext_bank_pkg::bus_req_t req;
  int n_mismatch = 0, checks = 0, n_tbs, n_ta, lat, early, n_soft = 0, n_hard = 0;
  external_bank_memory_controller u_external_bank_memory_controller (.clock, .rstn, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .req, .req_ready, .req_done, .req_error, .req_rdata, .soft_reset_req,
    .hard_reset_req, .soft_reset, .hard_reset, .ext_addr, .ext_wdata, .ext_rdata, .ext_data_oe_n, .ext_rd_wr,
    .transfer_begin_strobe, .chip_select, .write_strobe, .byte_lane_select, .output_strobe, .burst_beat_strobe,
    .transfer_ack, .ext_transfer_ack, .transfer_error_ack, .irq);
  ext_mem_model u_ext_mem_model (.clock, .chip_select, .ext_addr, .ack_delay, .ext_rdata, .ext_transfer_ack);
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (soft_reset === 1'b1) n_soft <= n_soft + 1;
    if (hard_reset === 1'b1) n_hard <= n_hard + 1;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge clock);
  endtask
  // Records what the far side saw during one request, up to and including its done cycle.
  task automatic go(input logic w, b, input logic [31:0] a, input logic [2:0] t, input logic [1:0] sz);
    req <= '{valid: 1'b1, write: w, burst: b, addr: a, addr_type: t, size: sz, wdata: 32'hc3c3_3c3c};
    do @(posedge clock); while (req_ready !== 1'b1);
    req.valid <= 1'b0;
    n_tbs = 0; n_ta = 0; lat = 0; early = 0;
    cs_or = 4'h0; ws_or = 4'h0; bls_or = 4'h0; tea_or = 1'b0; bbs_or = 1'b0;
    while (lat < 300) begin
      #1 lat++;
      n_tbs += transfer_begin_strobe;
      n_ta += transfer_ack;
      cs_or |= chip_select;
      ws_or |= write_strobe;
      bls_or |= byte_lane_select;
      tea_or |= transfer_error_ack;
      bbs_or |= burst_beat_strobe;
      if (req_done === 1'b1) break;
      if (soft_reset === 1'b1) early++;
      @(posedge clock);
    end
    check({31'h0, req_done}, 32'h1);
    got_err = req_error;
    got_rd = req_rdata;
  endtask
  task automatic t_regs;
    rd(ext_bank_pkg::off_wait_states);
    check(v, {28'h0, ext_bank_pkg::wait_reset});
    rd(8'h00);
    check(v, ext_bank_pkg::region_reset);
    rd(8'hfc);
    check(v, 32'h0);
    wr(8'h00, 32'hffff_ffff);
    rd(8'h00);
    check(v, ext_bank_pkg::region_wmask);
    $display("test regs done");
  endtask
  task automatic t_match;
    wr(8'h00, 32'h1000_5001);
    wr(8'h24, 32'hffff_f000);
    go(1'b0, 1'b0, 32'h1000_0004, 3'h5, 2'h2);
    check({31'h0, got_err}, 32'h0);
    check({28'h0, cs_or}, 32'h1);
    check(got_rd, 32'h4a5a_0004);
    go(1'b0, 1'b0, 32'h1000_0004, 3'h4, 2'h2);
    check({27'h0, got_err, cs_or}, 32'h10);
    go(1'b0, 1'b0, 32'h2000_0000, 3'h5, 2'h2);
    check({27'h0, got_err, cs_or}, 32'h10);
    wr(8'h24, 32'hffff_8000);
    go(1'b0, 1'b0, 32'h1000_0004, 3'h4, 2'h2);
    check({27'h0, got_err, cs_or}, 32'h1);
    $display("test match done");
  endtask
  task automatic t_wp;
    wr(8'h00, 32'h1000_5101);
    wr(ext_bank_pkg::off_mask, 32'h1);
    go(1'b1, 1'b0, 32'h1000_0000, 3'h5, 2'h2);
    check({26'h0, got_err, tea_or, cs_or}, 32'h0);
    check(32'(n_ta), 32'h0);
    rd(ext_bank_pkg::off_status);
    check(v & 32'h1, 32'h1);
    check({31'h0, irq}, 32'h1);
    wr(ext_bank_pkg::off_status, 32'h7);
    @(posedge clock);
    #1 check({31'h0, irq}, 32'h0);
    wr(ext_bank_pkg::off_sys_cfg, 32'h2);
    go(1'b1, 1'b0, 32'h1000_0000, 3'h5, 2'h2);
    check({26'h0, got_err, tea_or, cs_or}, 32'h30);
    go(1'b0, 1'b0, 32'h1000_0000, 3'h5, 2'h2);
    check({27'h0, got_err, cs_or}, 32'h1);
    $display("test protect done");
  endtask
  task automatic t_port;
    logic [1:0] p [4] = '{ext_bank_pkg::port_8, ext_bank_pkg::port_16, ext_bank_pkg::port_8, ext_bank_pkg::port_32};
    logic [1:0] s [4] = '{2'h2, 2'h2, 2'h1, 2'h2};
    logic [31:0] n [4] = '{32'h4, 32'h2, 32'h2, 32'h1};
    logic [31:0] r [4] = '{32'h4a4a_4a4a, 32'h4a5a_4a5a, 32'h0000_4a4a, 32'h4a5a_0000};
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, 32'h1000_5001 | {20'h0, p[i], 10'h0});
      go(1'b0, 1'b0, 32'h1000_0000, 3'h5, s[i]);
      check(32'(n_tbs), n[i]);
      check({31'h0, got_err}, 32'h0);
      check(got_rd, r[i]);
    end
    $display("test port done");
  endtask
  task automatic t_strobe;
    wr(8'h00, 32'h1000_5001);
    go(1'b1, 1'b0, 32'h1000_0000, 3'h5, 2'h2);
    check({27'h0, ws_or != 4'h0, bls_or}, 32'h10);
    wr(8'h00, 32'h1000_5021);
    go(1'b1, 1'b0, 32'h1000_0000, 3'h5, 2'h2);
    check({27'h0, bls_or != 4'h0, ws_or}, 32'h10);
    $display("test strobe done");
  endtask
  task automatic t_burst;
    wr(ext_bank_pkg::off_sys_cfg, 32'h1);
    wr(8'h00, 32'h1000_5001);
    go(1'b0, 1'b1, 32'h1000_0000, 3'h5, 2'h2);
    check(32'(n_ta), {28'h0, ext_bank_pkg::beats_short});
    check({31'h0, bbs_or}, 32'h1);
    wr(8'h00, 32'h1000_5041);
    go(1'b0, 1'b1, 32'h1000_0000, 3'h5, 2'h2);
    check(32'(n_ta), {28'h0, ext_bank_pkg::beats_long});
    $display("test burst done");
  endtask
  task automatic t_ext;
    int li;
    wr(8'h00, 32'h1000_5001);
    go(1'b0, 1'b0, 32'h1000_0010, 3'h5, 2'h2);
    li = lat;
    wr(8'h00, 32'h1000_5005);
    go(1'b0, 1'b0, 32'h1000_0010, 3'h5, 2'h2);
    check({30'h0, got_err, lat > li}, 32'h1);
    check(got_rd, 32'h4a5a_0010);
    $display("test ext ack done");
  endtask
  task automatic t_reset;
    wr(8'h00, 32'h1000_5001);
    fork
      go(1'b0, 1'b0, 32'h1000_0008, 3'h5, 2'h2);
      begin
        repeat (3) @(posedge clock);
        soft_reset_req <= 1'b1;
        @(posedge clock);
        soft_reset_req <= 1'b0;
      end
    join
    repeat (20) @(posedge clock);
    check(32'(early), 32'h0);
    check(32'(n_soft), 32'h1);
    hard_reset_req <= 1'b1;
    @(posedge clock);
    hard_reset_req <= 1'b0;
    repeat (20) @(posedge clock);
    check({32'(n_hard)} + 32'(n_soft), 32'h3);
    $display("test reset done");
  endtask
  initial begin
    rstn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    req = '0;
    soft_reset_req = 1'b0;
    hard_reset_req = 1'b0;
    ack_delay = 4'h5;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    t_regs();
    t_match();
    t_wp();
    t_port();
    t_strobe();
    t_burst();
    t_ext();
    t_reset();
    stop_test();
  end
  // The tests need a few hundred cycles; twenty thousand means something hung.
  initial begin
    #500000;
    n_mismatch++;
    $display("unexpected at %0t: run did not finish", $time);
    stop_test();
  end
endmodule
bind external_bank_memory_controller ext_bank_props u_ext_bank_props (.clock, .rstn, .reg_addr, .reg_wdata,
  .reg_wr, .req_done, .req_error, .soft_reset, .hard_reset, .ext_data_oe_n, .ext_rd_wr, .transfer_begin_strobe,
  .chip_select, .transfer_ack, .transfer_error_ack);
`default_nettype wire
